/* src/cot_csi2_tx_output_control.v */
// CSI-2 transmitter output control: pin state, forwarding, status, line stats
`timescale 1ns/1ps
`include "cot_consts.vh"
module cot_csi2_tx_output_control (
  input  wire        sys_clk_i,
  input  wire        nrst_i,
  input  wire        power_down_pin_n_i,
  input  wire [1:0]  rx_lock_i,
  input  wire [1:0]  rx_valid_i,
  input  wire [15:0] rx_data_i,
  input  wire [1:0]  rx_last_i,
  input  wire [1:0]  rx_fs_i,
  input  wire [1:0]  rx_err_i,
  output wire [1:0]  rx_ready_o,
  input  wire        i2c_scl_i,
  input  wire        i2c_sda_i,
  output wire        i2c_sda_o,
  output wire        i2c_sda_oe_o,
  output wire [1:0]  tx0_state_o,
  output wire        tx0_valid_o,
  output wire [7:0]  tx0_data_o,
  output wire        tx0_last_o,
  output wire [1:0]  tx1_state_o,
  output wire        tx1_valid_o,
  output wire [7:0]  tx1_data_o,
  output wire        tx1_last_o,
  output wire        tx1_clk_en_o,
  output wire        status_gpio_o,
  output wire        irq_o
);
  localparam [3:0] I_IDLE = 4'h0, I_DEV = 4'h1, I_DACK = 4'h2, I_REG = 4'h3, I_RACK = 4'h4;
  localparam [3:0] I_WR = 4'h5, I_WACK = 4'h6, I_RD = 4'h7, I_MACK = 4'h8;

  function [1:0] pin_state;
    input       power_down_pin;
    input       sleep_sel;
    input       drive;
    input       idle_lp;
    input [1:0] lock_m;
    input [1:0] fwd_m;
    begin
      if (!power_down_pin)
        pin_state = `COT_PIN_HIZ;
      else if (!sleep_sel)
        pin_state = `COT_PIN_HS0;
      else if (!drive)
        pin_state = `COT_PIN_HIZ;
      else if (lock_m == 2'h0)
        pin_state = idle_lp ? `COT_PIN_LP11 : `COT_PIN_HIZ;
      else if ((lock_m & fwd_m) == 2'h0)
        pin_state = `COT_PIN_LP11;
      else
        pin_state = `COT_PIN_VALID;
    end
  endfunction

  // Pin and cross-domain synchronisers
  reg  [1:0] pdb_s1_q, pdb_s2_q;
  reg  [1:0] lock_s1_q, lock_s2_q;
  reg  [2:0] scl_q, sda_q;
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pdb_s1_q  <= 2'h0;
      pdb_s2_q  <= 2'h0;
      lock_s1_q <= 2'h0;
      lock_s2_q <= 2'h0;
      scl_q     <= 3'h7;
      sda_q     <= 3'h7;
    end else begin
      pdb_s1_q  <= {1'b0, power_down_pin_n_i};
      pdb_s2_q  <= pdb_s1_q;
      lock_s1_q <= rx_lock_i;
      lock_s2_q <= lock_s1_q;
      scl_q     <= {scl_q[1:0], i2c_scl_i};
      sda_q     <= {sda_q[1:0], i2c_sda_i};
    end
  end

  // Registers
  reg  [7:0] glb_q, gate_q, mode_q, lane_q;
  reg  [15:0] lcnt_q, llen_q;
  reg        pass_q, sync_q;
  wire [7:0] sts = {6'h00, sync_q, pass_q};
  wire       repl = mode_q[`COT_MODE_REPL];
  wire [1:0] fwd_off = gate_q[`COT_GATE_OFF+:2];
  wire [1:0] map1 = gate_q[`COT_GATE_MAP+:2];
  wire [1:0] map0 = ~map1;
  wire [1:0] lock = lock_s2_q;

  // Serial register port
  wire       scl_rise = scl_q[1] & ~scl_q[2];
  wire       scl_fall = ~scl_q[1] & scl_q[2];
  wire       i_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  wire       i_stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  reg  [3:0] ist_q;
  reg  [3:0] bitc_q;
  reg  [7:0] sh_q, tsh_q, ptr_q;
  reg        rw_q, oe_q, wr_q;
  reg  [7:0] rdata;
  always @* begin
    case (ptr_q)
      `COT_RA_GLOBAL:   rdata = glb_q;
      `COT_RA_FWD_GATE: rdata = gate_q;
      `COT_RA_FWD_MODE: rdata = mode_q;
      `COT_RA_LANE:     rdata = lane_q;
      `COT_RA_STATUS:   rdata = sts;
      `COT_RA_LCNT_HI:  rdata = lcnt_q[15:8];
      `COT_RA_LCNT_LO:  rdata = lcnt_q[7:0];
      `COT_RA_LLEN_HI:  rdata = llen_q[15:8];
      `COT_RA_LLEN_LO:  rdata = llen_q[7:0];
      default:          rdata = 8'h00;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ist_q  <= I_IDLE;
      bitc_q <= 4'h0;
      sh_q   <= 8'h00;
      tsh_q  <= 8'h00;
      ptr_q  <= 8'h00;
      rw_q   <= 1'b0;
      oe_q   <= 1'b0;
      wr_q   <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (i_start) begin
        ist_q  <= I_DEV;
        bitc_q <= 4'h0;
        oe_q   <= 1'b0;
      end else if (i_stop) begin
        ist_q <= I_IDLE;
        oe_q  <= 1'b0;
      end else if (scl_rise) begin
        if (ist_q == I_DEV || ist_q == I_REG || ist_q == I_WR) begin
          sh_q   <= {sh_q[6:0], sda_q[1]};
          bitc_q <= bitc_q + 4'h1;
        end else if (ist_q == I_MACK && sda_q[1]) begin
          ist_q <= I_IDLE; // Master NACK ends the read
        end
      end else if (scl_fall) begin
        case (ist_q)
          I_DEV: if (bitc_q == 4'h8) begin
            if (sh_q[7:1] == `COT_I2C_ADDR) begin
              ist_q <= I_DACK;
              oe_q  <= 1'b1;
              rw_q  <= sh_q[0];
            end else begin
              ist_q <= I_IDLE;
            end
          end
          I_DACK, I_MACK: begin
            if (rw_q) begin
              ist_q  <= I_RD;
              tsh_q  <= rdata;
              oe_q   <= ~rdata[7];
              bitc_q <= 4'h1;
            end else begin
              ist_q  <= I_REG;
              oe_q   <= 1'b0;
              bitc_q <= 4'h0;
            end
          end
          I_REG: if (bitc_q == 4'h8) begin
            ptr_q <= sh_q;
            ist_q <= I_RACK;
            oe_q  <= 1'b1;
          end
          I_RACK, I_WACK: begin
            ist_q  <= I_WR;
            oe_q   <= 1'b0;
            bitc_q <= 4'h0;
          end
          I_WR: if (bitc_q == 4'h8) begin
            wr_q  <= 1'b1;
            ist_q <= I_WACK;
            oe_q  <= 1'b1;
          end
          I_RD: begin
            if (bitc_q == 4'h8) begin
              ist_q <= I_MACK;
              oe_q  <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
            end else begin
              tsh_q  <= {tsh_q[6:0], 1'b0};
              oe_q   <= ~tsh_q[6];
              bitc_q <= bitc_q + 4'h1;
            end
          end
          default: ist_q <= I_IDLE;
        endcase
      end
      // Pointer advances after each written byte
      if (wr_q)
        ptr_q <= ptr_q + 8'h01;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      glb_q  <= `COT_GLB_RST;
      gate_q <= `COT_GATE_RST;
      mode_q <= `COT_MODE_RST;
      lane_q <= `COT_LANE_RST;
    end else if (wr_q) begin
      case (ptr_q)
        `COT_RA_GLOBAL:   glb_q  <= sh_q;
        `COT_RA_FWD_GATE: gate_q <= sh_q;
        `COT_RA_FWD_MODE: mode_q <= sh_q;
        `COT_RA_LANE:     lane_q <= sh_q;
        default:          ;
      endcase
    end
  end

  // Video buffers
  wire [3:0]  pop_w;
  wire [1:0]  b_avail, b_last;
  wire [15:0] b_data;
  genvar p, t;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_buf
      cot_vbuf u_buf (
        .sys_clk_i   (sys_clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (rx_valid_i[p]),
        .in_data_i   (rx_data_i[8*p+:8]),
        .in_last_i   (rx_last_i[p]),
        .in_ready_o  (rx_ready_o[p]),
        .out_pop_i   (pop_w[p] | pop_w[2+p]),
        .out_data_o  (b_data[8*p+:8]),
        .out_last_o  (b_last[p]),
        .out_avail_o (b_avail[p])
      );
    end
  endgenerate

  // Pin state per transmit port; port 1 follows port 0 mapping when replicating
  wire [1:0] m1_eff = repl ? map0 : map1;
  wire [1:0] st0 = pin_state(pdb_s2_q[0], glb_q[`COT_GLB_SLEEP], glb_q[`COT_GLB_DRIVE],
                             glb_q[`COT_GLB_IDLE_LP], lock & map0, ~fwd_off);
  wire [1:0] st1 = pin_state(pdb_s2_q[0], glb_q[`COT_GLB_SLEEP], glb_q[`COT_GLB_DRIVE],
                             glb_q[`COT_GLB_IDLE_LP], lock & m1_eff, ~fwd_off);

  // Forwarding engines, round robin between eligible buffers
  wire [15:0] e_data;
  wire [1:0]  e_valid, e_last;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_eng
      reg        busy_q, port_q, rr_q, v_q, l_q;
      reg  [7:0] d_q;
      wire [1:0] mp = (t == 0) ? map0 : (repl ? 2'h0 : map1);
      wire [1:0] stt = (t == 0) ? st0 : st1;
      wire [1:0] elig = b_avail & mp & ~fwd_off & {2{stt == `COT_PIN_VALID}};
      wire       pick = elig[rr_q] ? rr_q : ~rr_q;
      assign pop_w[2*t+:2] = {busy_q & port_q, busy_q & ~port_q};
      assign e_data[8*t+:8] = d_q;
      assign e_valid[t] = v_q;
      assign e_last[t] = l_q;
      always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
          busy_q <= 1'b0;
          port_q <= 1'b0;
          rr_q   <= 1'b0;
          v_q    <= 1'b0;
          l_q    <= 1'b0;
          d_q    <= 8'h00;
        end else begin
          v_q <= busy_q;
          l_q <= busy_q & b_last[port_q];
          d_q <= b_data[8*port_q+:8];
          if (busy_q) begin
            if (b_last[port_q])
              busy_q <= 1'b0;
          end else if (elig != 2'h0) begin
            busy_q <= 1'b1;
            port_q <= pick;
            rr_q   <= ~pick;
          end
        end
      end
    end
  endgenerate

  // Output stage and status
  reg  [1:0]  tx0_st_q, tx1_st_q;
  reg         tx0_v_q, tx0_l_q, tx1_v_q, tx1_l_q, clk1_q, gpio_q, irq_q;
  reg  [7:0]  tx0_d_q, tx1_d_q, sts_prev_q;
  reg  [1:0]  fs_seen_q;
  reg  [15:0] win_q;
  wire [1:0]  need = map0 & ~fwd_off;
  wire [1:0]  seen_d = fs_seen_q | (rx_fs_i & need);
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tx0_st_q   <= `COT_PIN_HIZ;
      tx1_st_q   <= `COT_PIN_HIZ;
      tx0_v_q    <= 1'b0;
      tx0_l_q    <= 1'b0;
      tx0_d_q    <= 8'h00;
      tx1_v_q    <= 1'b0;
      tx1_l_q    <= 1'b0;
      tx1_d_q    <= 8'h00;
      clk1_q     <= 1'b0;
      pass_q     <= 1'b0;
      sync_q     <= 1'b0;
      fs_seen_q  <= 2'h0;
      win_q      <= 16'h0000;
      gpio_q     <= 1'b0;
      irq_q      <= 1'b0;
      sts_prev_q <= 8'h00;
    end else begin
      tx0_st_q <= st0;
      tx0_v_q  <= e_valid[0];
      tx0_l_q  <= e_last[0];
      tx0_d_q  <= e_data[7:0];
      tx1_st_q <= repl ? st0 : st1;
      tx1_v_q  <= repl ? e_valid[0] : e_valid[1];
      tx1_l_q  <= repl ? e_last[0] : e_last[1];
      tx1_d_q  <= repl ? e_data[7:0] : e_data[15:8];
      clk1_q   <= repl | (map1 != 2'h0);
      if (st0 != `COT_PIN_VALID || (rx_err_i & map0) != 2'h0)
        pass_q <= 1'b0;
      else if (e_valid[0] & e_last[0])
        pass_q <= 1'b1;
      // Sync: needed ports must see frame start within the window
      if (!mode_q[`COT_MODE_SYNC] || (lock & need) != need) begin
        sync_q    <= 1'b0;
        fs_seen_q <= 2'h0;
        win_q     <= 16'h0000;
      end else if (need != 2'h0 && seen_d == need) begin
        sync_q    <= 1'b1;
        fs_seen_q <= 2'h0;
        win_q     <= 16'h0000;
      end else if (seen_d != 2'h0) begin
        fs_seen_q <= seen_d;
        win_q     <= win_q + 16'h0001;
        if (win_q == `COT_SYNC_WIN) begin
          sync_q    <= 1'b0;
          fs_seen_q <= 2'h0;
          win_q     <= 16'h0000;
        end
      end
      gpio_q     <= glb_q[`COT_GLB_GPIO] & pass_q;
      sts_prev_q <= sts;
      irq_q      <= glb_q[`COT_GLB_IRQ] & (sts != sts_prev_q);
    end
  end

  // Line statistics on the selected receive port, latched per frame
  reg  [15:0] lc_run_q, len_run_q, len_last_q;
  wire        ms = glb_q[`COT_GLB_MSEL];
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      lc_run_q   <= 16'h0000;
      len_run_q  <= 16'h0000;
      len_last_q <= 16'h0000;
      lcnt_q     <= 16'h0000;
      llen_q     <= 16'h0000;
    end else begin
      // Mixed virtual channels on one port blend into these counts
      if (rx_fs_i[ms]) begin
        lcnt_q   <= lc_run_q;
        llen_q   <= len_last_q;
        lc_run_q <= 16'h0000;
      end else if (rx_valid_i[ms] & rx_last_i[ms]) begin
        lc_run_q <= lc_run_q + 16'h0001;
      end
      if (rx_valid_i[ms]) begin
        if (rx_last_i[ms]) begin
          len_last_q <= len_run_q + 16'h0001;
          len_run_q  <= 16'h0000;
        end else begin
          len_run_q <= len_run_q + 16'h0001;
        end
      end
    end
  end

  assign i2c_sda_o     = 1'b0;
  assign i2c_sda_oe_o  = oe_q;
  assign tx0_state_o   = tx0_st_q;
  assign tx0_valid_o   = tx0_v_q;
  assign tx0_data_o    = tx0_d_q;
  assign tx0_last_o    = tx0_l_q;
  assign tx1_state_o   = tx1_st_q;
  assign tx1_valid_o   = tx1_v_q;
  assign tx1_data_o    = tx1_d_q;
  assign tx1_last_o    = tx1_l_q;
  assign tx1_clk_en_o  = clk1_q;
  assign status_gpio_o = gpio_q;
  assign irq_o         = irq_q;
endmodule // cot_csi2_tx_output_control

/* src/cot_consts.vh */
// Constants for the CSI-2 transmitter output control block
`ifndef COT_CONSTS_VH
`define COT_CONSTS_VH
// Device address on the serial register port, value is arbitrary
`define COT_I2C_ADDR    7'h3D
// Register offsets
`define COT_RA_GLOBAL   8'h02
`define COT_RA_FWD_GATE 8'h20
`define COT_RA_FWD_MODE 8'h21
`define COT_RA_LANE     8'h33
`define COT_RA_STATUS   8'h35
`define COT_RA_LCNT_HI  8'h73
`define COT_RA_LCNT_LO  8'h74
`define COT_RA_LLEN_HI  8'h75
`define COT_RA_LLEN_LO  8'h76
// Reset values
`define COT_GLB_RST     8'h03
`define COT_GATE_RST    8'h00
`define COT_MODE_RST    8'h00
`define COT_LANE_RST    8'h00
// global_setup_reg fields
`define COT_GLB_SLEEP   0
`define COT_GLB_DRIVE   1
`define COT_GLB_IDLE_LP 2
`define COT_GLB_GPIO    3
`define COT_GLB_IRQ     4
`define COT_GLB_MSEL    5
// forward_port_gate_reg fields: off bits [1:0], tx1 map bits [5:4]
`define COT_GATE_OFF    0
`define COT_GATE_MAP    4
// forward_mode_reg fields
`define COT_MODE_SYNC   4
`define COT_MODE_REPL   7
// tx_status_reg fields
`define COT_STS_PASS    0
`define COT_STS_SYNC    1
// CSI-2 pin states
`define COT_PIN_HIZ     2'h0
`define COT_PIN_HS0     2'h1
`define COT_PIN_LP11    2'h2
`define COT_PIN_VALID   2'h3
// Video buffer: 16 kB per receive port
`define COT_BUF_AW      14
`define COT_BUF_DEPTH   15'h4000
// Frame start alignment window for synchronized forwarding, in cycles
`define COT_SYNC_WIN    16'h0400
`endif

/* src/cot_vbuf.v */
// Per-port video packet buffer that releases only complete packets
`timescale 1ns/1ps
`include "cot_consts.vh"
module cot_vbuf (
  input  wire       sys_clk_i,
  input  wire       nrst_i,
  input  wire       in_valid_i,
  input  wire [7:0] in_data_i,
  input  wire       in_last_i,
  output wire       in_ready_o,
  input  wire       out_pop_i,
  output wire [7:0] out_data_o,
  output wire       out_last_o,
  output wire       out_avail_o
);
  reg [8:0]               mem_q [0:(1<<`COT_BUF_AW)-1];
  reg [`COT_BUF_AW-1:0]   wp_q;
  reg [`COT_BUF_AW-1:0]   rp_q;
  reg [`COT_BUF_AW:0]     used_q;
  reg [`COT_BUF_AW:0]     pkts_q;
  reg                     rdy_q;
  wire                    wr = in_valid_i && (used_q != `COT_BUF_DEPTH);
  wire                    rd = out_pop_i && (pkts_q != 15'h0000);
  wire                    rd_last = mem_q[rp_q][8];
  wire [`COT_BUF_AW:0]    used_d = used_q + {14'h0000, wr} - {14'h0000, rd};

  assign out_data_o  = mem_q[rp_q][7:0];
  assign out_last_o  = rd_last;
  assign out_avail_o = (pkts_q != 15'h0000);
  assign in_ready_o  = rdy_q;

  always @(posedge sys_clk_i) begin
    if (wr)
      mem_q[wp_q] <= {in_last_i, in_data_i};
  end

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wp_q   <= 14'h0000;
      rp_q   <= 14'h0000;
      used_q <= 15'h0000;
      pkts_q <= 15'h0000;
      rdy_q  <= 1'b0;
    end else begin
      if (wr)
        wp_q <= wp_q + 14'h0001;
      if (rd)
        rp_q <= rp_q + 14'h0001;
      used_q <= used_d;
      // Registered ready needs no margin since used_d is exact
      rdy_q  <= (used_d < `COT_BUF_DEPTH);
      // Packet counted only once its last byte is stored
      pkts_q <= pkts_q + {14'h0000, wr & in_last_i} - {14'h0000, rd & rd_last};
    end
  end
endmodule // cot_vbuf

/* test/cot_csi_rx_model.sv */
// Behavioural CSI-2 receiver that collects packets from one transmit port
`timescale 1ns/1ps
`include "cot_consts.vh"
module cot_csi_rx_model (
  input  wire         sys_clk_i,
  input  wire         nrst_i,
  input  wire  [1:0]  state_i,
  input  wire         valid_i,
  input  wire  [7:0]  data_i,
  input  wire         last_i,
  output logic        pkt_done_o,
  output logic [15:0] pkt_len_o,
  output logic [15:0] pkt_sum_o
);
  logic [15:0] len_q;
  logic [15:0] sum_q;
  // Bytes outside the valid pin state never reach a real receiver
  always @(posedge sys_clk_i) begin
    pkt_done_o <= 1'b0;
    if (!nrst_i) begin
      len_q <= 16'h0000;
      sum_q <= 16'h0000;
    end else if (valid_i && state_i == `COT_PIN_VALID) begin
      len_q <= last_i ? 16'h0000 : len_q + 16'h0001;
      sum_q <= last_i ? 16'h0000 : sum_q + {8'h00, data_i};
      if (last_i) begin
        pkt_done_o <= 1'b1;
        pkt_len_o  <= len_q + 16'h0001;
        pkt_sum_o  <= sum_q + {8'h00, data_i};
      end
    end
  end
endmodule // cot_csi_rx_model

/* test/cot_txc_monitor.sv */
// Port assertions for the CSI-2 transmitter output control
`timescale 1ns/1ps
`include "cot_consts.vh"
module cot_txc_monitor (
  input wire       sys_clk_i,
  input wire       nrst_i,
  input wire       power_down_pin_n_i,
  input wire [1:0] rx_lock_i,
  input wire [1:0] tx0_state_o,
  input wire       tx0_valid_o,
  input wire [7:0] tx0_data_o,
  input wire       tx0_last_o,
  input wire [1:0] tx1_state_o,
  input wire       tx1_valid_o,
  input wire [7:0] tx1_data_o,
  input wire       tx1_last_o,
  input wire       tx1_clk_en_o,
  input wire       status_gpio_o,
  input wire       irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Pin inputs pass two sync stages and the output register, so four cycles are just enough
  property p_pdn_hiz;
    (!power_down_pin_n_i) [*4] |-> tx0_state_o == `COT_PIN_HIZ && tx1_state_o == `COT_PIN_HIZ;
  endproperty
  a_pdn_hiz: assert property (p_pdn_hiz) else $error("pins not high impedance in power down");
  property p_nolock;
    (rx_lock_i == 2'b00) [*4] |-> tx0_state_o != `COT_PIN_VALID && tx1_state_o != `COT_PIN_VALID;
  endproperty
  a_nolock: assert property (p_nolock) else $error("valid state without any lock");
  property p_valid_state;
    tx0_valid_o |-> tx0_state_o == `COT_PIN_VALID;
  endproperty
  a_valid_state: assert property (p_valid_state) else $error("data outside valid state");
  property p_pkt_whole;
    tx0_valid_o && !tx0_last_o |=> tx0_valid_o;
  endproperty
  a_pkt_whole: assert property (p_pkt_whole) else $error("gap inside a forwarded packet");
  property p_repl_copy;
    tx1_clk_en_o && tx0_valid_o |-> tx1_valid_o && tx1_data_o == tx0_data_o && tx1_last_o == tx0_last_o;
  endproperty
  a_repl_copy: assert property (p_repl_copy) else $error("port 1 differs from port 0");
  property p_pass_clear;
    (tx0_state_o != `COT_PIN_VALID) [*4] |-> !status_gpio_o;
  endproperty
  a_pass_clear: assert property (p_pass_clear) else $error("pass kept without valid output");
  property p_pass_rise;
    $rose(status_gpio_o) |-> tx0_state_o == `COT_PIN_VALID;
  endproperty
  a_pass_rise: assert property (p_pass_rise) else $error("pass raised outside valid state");
  property p_irq_pulse;
    irq_o |=> !irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
endmodule // cot_txc_monitor
bind cot_csi2_tx_output_control cot_txc_monitor i_mon (
  .sys_clk_i, .nrst_i, .power_down_pin_n_i, .rx_lock_i, .tx0_state_o, .tx0_valid_o, .tx0_data_o,
  .tx0_last_o, .tx1_state_o, .tx1_valid_o, .tx1_data_o, .tx1_last_o, .tx1_clk_en_o, .status_gpio_o, .irq_o
);

/* test/tb_csi2_tx_output_control.sv */
// Self-checking bench for the CSI-2 transmitter output control
`timescale 1ns/1ps
`include "cot_consts.vh"
module tb_csi2_tx_output_control;
  logic        sys_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        power_down_pin_n_i = 1'b1;
  logic [1:0]  rx_lock_i = 2'b00;
  logic [1:0]  rx_valid_i = 2'b00;
  logic [15:0] rx_data_i = 16'h0000;
  logic [1:0]  rx_last_i = 2'b00;
  logic [1:0]  rx_fs_i = 2'b00;
  logic [1:0]  rx_err_i = 2'b00;
  logic        i2c_scl_i = 1'b1;
  logic        sda_tb = 1'b1;
  wire  [1:0]  rx_ready_o, tx0_state_o, tx1_state_o;
  wire         i2c_sda_o, i2c_sda_oe_o, tx0_valid_o, tx0_last_o, tx1_valid_o, tx1_last_o;
  wire         tx1_clk_en_o, status_gpio_o, irq_o, d0, d1;
  wire  [7:0]  tx0_data_o, tx1_data_o;
  wire  [15:0] l0, s0, l1, s1;
  // Open-drain line with pull-up
  wire         i2c_sda_i = sda_tb & ~(i2c_sda_oe_o & ~i2c_sda_o);
  logic [31:0] q0[$], q1[$];
  int          miscompares = 0, total_checks = 0, irq_seen = 0, n;
  logic        tp;
  logic [1:0]  tl, e0, e1;
  logic [7:0]  g, f;
  // Rows: power-down pin, global, gate, lock, tx0 state, tx1 state
  logic [22:0] tbl [8] = '{
    {1'b0, 8'h03, 8'h00, 2'b11, `COT_PIN_HIZ, `COT_PIN_HIZ},
    {1'b1, 8'h02, 8'h00, 2'b11, `COT_PIN_HS0, `COT_PIN_HS0},
    {1'b1, 8'h01, 8'h00, 2'b11, `COT_PIN_HIZ, `COT_PIN_HIZ},
    {1'b1, 8'h03, 8'h00, 2'b00, `COT_PIN_HIZ, `COT_PIN_HIZ},
    {1'b1, 8'h07, 8'h00, 2'b00, `COT_PIN_LP11, `COT_PIN_LP11},
    {1'b1, 8'h03, 8'h01, 2'b01, `COT_PIN_LP11, `COT_PIN_HIZ},
    {1'b1, 8'h03, 8'h00, 2'b10, `COT_PIN_VALID, `COT_PIN_HIZ},
    {1'b1, 8'h03, 8'h20, 2'b10, `COT_PIN_HIZ, `COT_PIN_VALID}
  };
  cot_csi2_tx_output_control i_dut (
    .sys_clk_i, .nrst_i, .power_down_pin_n_i, .rx_lock_i, .rx_valid_i, .rx_data_i, .rx_last_i, .rx_fs_i,
    .rx_err_i, .rx_ready_o, .i2c_scl_i, .i2c_sda_i, .i2c_sda_o, .i2c_sda_oe_o, .tx0_state_o, .tx0_valid_o,
    .tx0_data_o, .tx0_last_o, .tx1_state_o, .tx1_valid_o, .tx1_data_o, .tx1_last_o, .tx1_clk_en_o,
    .status_gpio_o, .irq_o
  );
  cot_csi_rx_model i_rx0 (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .state_i(tx0_state_o), .valid_i(tx0_valid_o),
    .data_i(tx0_data_o), .last_i(tx0_last_o), .pkt_done_o(d0), .pkt_len_o(l0), .pkt_sum_o(s0));
  cot_csi_rx_model i_rx1 (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .state_i(tx1_state_o), .valid_i(tx1_valid_o),
    .data_i(tx1_data_o), .last_i(tx1_last_o), .pkt_done_o(d1), .pkt_len_o(l1), .pkt_sum_o(s1));
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string w);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic check_pkt(input logic [31:0] got, input logic [31:0] exp, input string w);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Each step is two clocks, so the serial clock runs at 800 ns
  task automatic bus(input logic c, input logic d);
    repeat (2) @(posedge sys_clk_i);
    #5;
    i2c_scl_i = c;
    sda_tb = d;
  endtask
  task automatic xbit(input logic b, output logic r);
    bus(1'b0, sda_tb);
    bus(1'b0, b);
    bus(1'b1, b);
    r = i2c_sda_i;
    bus(1'b1, b);
  endtask
  task automatic cond(input logic s);
    bus(1'b0, sda_tb);
    bus(1'b0, s);
    bus(1'b1, s);
    bus(1'b1, ~s);
  endtask
  task automatic wbyte(input logic [7:0] v, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(v[i], r);
    xbit(1'b1, r);
    check_val({15'h0, ~r}, {15'h0, ack}, "acknowledge");
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    cond(1'b1);
    wbyte({`COT_I2C_ADDR, 1'b0}, 1'b1);
    wbyte(a, 1'b1);
    wbyte(d, 1'b1);
    cond(1'b0);
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string w);
    logic [7:0] d;
    logic       r;
    cond(1'b1);
    wbyte({`COT_I2C_ADDR, 1'b0}, 1'b1);
    wbyte(a, 1'b1);
    cond(1'b1);
    wbyte({`COT_I2C_ADDR, 1'b1}, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(1'b1, r);
    cond(1'b0);
    check_val({8'h00, d & m}, {8'h00, e}, w);
  endtask
  task automatic send_pkt(input int p, input int len, input logic t0, input logic t1);
    logic [15:0] sum;
    logic [7:0]  b;
    sum = 16'h0000;
    for (int i = 0; i < len; i++) begin
      b = 8'($urandom);
      sum = sum + {8'h00, b};
      if (i == len - 1 && t0)
        q0.push_back({16'(len), sum});
      if (i == len - 1 && t1)
        q1.push_back({16'(len), sum});
      rx_valid_i[p] = 1'b1;
      rx_data_i[8*p +: 8] = b;
      rx_last_i[p] = (i == len - 1);
      @(posedge sys_clk_i);
      #5;
      rx_valid_i[p] = 1'b0;
      rx_last_i[p] = 1'b0;
      // Gaps expose a packet released before its last byte
      repeat ($urandom_range(1, 4)) @(posedge sys_clk_i);
      #5;
    end
  endtask
  task automatic pulse(input logic [1:0] fs, input logic [1:0] er);
    rx_fs_i = fs;
    rx_err_i = er;
    @(posedge sys_clk_i);
    #5;
    rx_fs_i = 2'b00;
    rx_err_i = 2'b00;
    repeat (4) @(posedge sys_clk_i);
    #5;
  endtask
  task automatic drain;
    for (int i = 0; i < 300 && q0.size() + q1.size() > 0; i++)
      @(posedge sys_clk_i);
    #5;
  endtask
  always @(posedge sys_clk_i) begin
    if (d0 === 1'b1)
      check_pkt({l0, s0}, q0.size() ? q0.pop_front() : 32'hXXXXXXXX, "tx0 packet");
    if (d1 === 1'b1)
      check_pkt({l1, s1}, q1.size() ? q1.pop_front() : 32'hXXXXXXXX, "tx1 packet");
    if (irq_o === 1'b1)
      irq_seen++;
  end
  initial begin
    #5_000_000;
    miscompares++;
    $display("unexpected at %0t: run timed out", $time);
    close_out();
  end
  initial begin
    void'($urandom(15));
    repeat (20) @(posedge sys_clk_i);
    #5;
    nrst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reg_chk(`COT_RA_GLOBAL, 8'hFF, `COT_GLB_RST, "global");
    reg_chk(`COT_RA_FWD_GATE, 8'hFF, `COT_GATE_RST, "gate");
    reg_chk(`COT_RA_FWD_MODE, 8'hFF, `COT_MODE_RST, "mode");
    reg_wr(`COT_RA_STATUS, 8'hFF);
    reg_chk(`COT_RA_STATUS, 8'hFF, 8'h00, "status read only");
    reg_chk(8'h50, 8'hFF, 8'h00, "unmapped");
    cond(1'b1);
    wbyte({`COT_I2C_ADDR ^ 7'h01, 1'b0}, 1'b0);
    cond(1'b0);
    check_val({14'h0000, rx_ready_o}, 16'h0003, "buffer room");
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      {tp, g, f, tl, e0, e1} = tbl[i];
      reg_wr(`COT_RA_GLOBAL, g);
      reg_wr(`COT_RA_FWD_GATE, f);
      power_down_pin_n_i = tp;
      rx_lock_i = tl;
      repeat (8) @(posedge sys_clk_i);
      #5;
      check_val({12'h000, tx0_state_o, tx1_state_o}, {12'h000, e0, e1}, "pin state");
    end
    $display("test pin states done");
    power_down_pin_n_i = 1'b1;
    rx_lock_i = 2'b11;
    reg_wr(`COT_RA_GLOBAL, 8'h0B);
    reg_wr(`COT_RA_FWD_GATE, 8'h00);
    send_pkt(1, $urandom_range(2, 9), 1'b1, 1'b0);
    send_pkt(0, $urandom_range(2, 9), 1'b1, 1'b0);
    drain();
    reg_chk(`COT_RA_STATUS, 8'h01, 8'h01, "pass");
    check_val({15'h0, status_gpio_o}, 16'h0001, "status pin");
    pulse(2'b00, 2'b01);
    reg_chk(`COT_RA_STATUS, 8'h01, 8'h00, "pass after error");
    $display("test forwarding done");
    n = $urandom_range(4, 12);
    pulse(2'b01, 2'b00);
    repeat (3) send_pkt(0, n, 1'b1, 1'b0);
    pulse(2'b01, 2'b00);
    send_pkt(0, 2, 1'b1, 1'b0);
    drain();
    reg_chk(`COT_RA_LCNT_HI, 8'hFF, 8'h00, "lines high");
    reg_chk(`COT_RA_LCNT_LO, 8'hFF, 8'h03, "lines low");
    reg_chk(`COT_RA_LLEN_HI, 8'hFF, 8'h00, "length high");
    reg_chk(`COT_RA_LLEN_LO, 8'hFF, 8'(n), "length low");
    // Statistics moved to receive port 1; a length unlike port 0's shows the switch
    reg_wr(`COT_RA_GLOBAL, 8'h2B);
    pulse(2'b10, 2'b00);
    send_pkt(1, 13, 1'b1, 1'b0);
    pulse(2'b10, 2'b00);
    drain();
    reg_chk(`COT_RA_LLEN_LO, 8'hFF, 8'h0D, "port 1 length");
    $display("test line figures done");
    reg_wr(`COT_RA_LANE, 8'h01);
    reg_wr(`COT_RA_FWD_MODE, 8'h80);
    check_val({15'h0, tx1_clk_en_o}, 16'h0001, "port 1 clock lane");
    send_pkt(0, $urandom_range(3, 9), 1'b1, 1'b1);
    send_pkt(1, $urandom_range(3, 9), 1'b1, 1'b1);
    drain();
    reg_wr(`COT_RA_FWD_MODE, 8'h00);
    $display("test replicate done");
    reg_chk(`COT_RA_STATUS, 8'h02, 8'h00, "sync while off");
    check_val(16'(irq_seen), 16'h0000, "masked interrupt");
    reg_wr(`COT_RA_GLOBAL, 8'h1B);
    reg_wr(`COT_RA_FWD_MODE, 8'h10);
    pulse(2'b11, 2'b00);
    reg_chk(`COT_RA_STATUS, 8'h02, 8'h02, "sync");
    check_val(16'(irq_seen > 0), 16'h0001, "interrupt");
    check_val(16'(q0.size() + q1.size()), 16'h0000, "packets lost");
    $display("test sync done");
    close_out();
  end
endmodule // tb_csi2_tx_output_control
